/* inc/twp_pkg.sv */
// package: register map, field positions and codes of the two-wire port
package twp_pkg;
  // ------------------------------------------------------------
  // register indices (printed offsets) and byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_FLG = 8'h0c;
  localparam logic [7:0] IDX_BUF = 8'h13;
  localparam logic [7:0] IDX_CTL = 8'h14;
  localparam logic [7:0] IDX_ADR = 8'h15;
  localparam logic [7:0] IDX_IEN = 8'h8c;
  localparam logic [7:0] IDX_STS = 8'h94;
  localparam logic [9:0] A_FLG   = {IDX_FLG, 2'b00};
  localparam logic [9:0] A_BUF   = {IDX_BUF, 2'b00};
  localparam logic [9:0] A_CTL   = {IDX_CTL, 2'b00};
  localparam logic [9:0] A_ADR   = {IDX_ADR, 2'b00};
  localparam logic [9:0] A_IEN   = {IDX_IEN, 2'b00};
  localparam logic [9:0] A_STS   = {IDX_STS, 2'b00};
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_FLG = 8'h00;
  localparam logic [7:0] RST_BUF = 8'h00;
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [7:0] RST_ADR = 8'h00;
  localparam logic [7:0] RST_IEN = 8'h00;
  localparam logic [7:0] RST_STS = 8'h00;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTL_WRITE_COLLISION_FLAG  = 7;
  localparam int CTL_OVF   = 6;
  localparam int CTL_EN    = 5;
  localparam int CTL_CKP   = 4;
  localparam int STS_DNA   = 5;
  localparam int STS_STOP  = 4;
  localparam int STS_START = 3;
  localparam int STS_RNW   = 2;
  localparam int STS_UA    = 1;
  localparam int STS_BF    = 0;
  localparam int FLG_PORT  = 3;
  // ------------------------------------------------------------
  // mode codes and protocol constants
  // ------------------------------------------------------------
  localparam logic [3:0] MODE_S7      = 4'h6;
  localparam logic [3:0] MODE_S10     = 4'h7;
  localparam logic [3:0] MODE_FW_MST  = 4'hb;
  localparam logic [3:0] MODE_S7_SP   = 4'he;
  localparam logic [3:0] MODE_S10_SP  = 4'hf;
  localparam logic [4:0] TEN_BIT_TAG  = 5'h1e;
  localparam logic [6:0] GEN_CALL     = 7'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_SKIP} twp_st_t;
  typedef enum logic [1:0] {AP_FIRST, AP_SECOND, AP_DATA} twp_aph_t;
endpackage

/* hdl/twp_sync.sv */
// module: two-flop synchroniser with edge detection for one bus line
`timescale 1ns/1ps
module twp_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      lvl,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } twp_sync_t;

  twp_sync_t q_ff;
  twp_sync_t nxt_q;

  // reset high: an idle bus rests high, so no false edge at release
  always_comb begin
    nxt_q.s1 = din;
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= '1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign lvl  = q_ff.s2;
  assign rise = q_ff.s2 & ~q_ff.s3;
  assign fall = ~q_ff.s2 & q_ff.s3;
endmodule // twp_sync

/* hdl/twp_shreg.sv */
// module: byte shift register, msb first, with parallel load
`timescale 1ns/1ps
module twp_shreg #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ld,
  input  wire logic [W-1:0] ld_val,
  input  wire logic         sh,
  input  wire logic         sh_bit,
  output logic [W-1:0]      q
);
  typedef struct packed {
    logic [W-1:0] sr;
  } twp_shreg_t;

  twp_shreg_t q_ff;
  twp_shreg_t nxt_q;

  // load wins over shift
  always_comb begin
    nxt_q = q_ff;
    if (ld) begin
      nxt_q.sr = ld_val;
    end else if (sh) begin
      nxt_q.sr = {q_ff.sr[W-2:0], sh_bit};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff.sr;
endmodule // twp_shreg

/* hdl/twp_port.sv */
// module: two-wire bus slave port with apb register file
//
// Summary of operation
// - idle bus: both lines released high
// - lines only pulled low or released
// - start: data falls while clock high
// - stop: data rises while clock high
// - transmitter changes data only clock low
// - direction bit sets transmitter and receiver roles
// - seven-bit address plus direction, one byte
// - ten-bit address: two bytes, tagged first
// - whole bytes, unlimited; receiver acknowledges each; port acks only with BF and overflow clear
// - withheld acknowledge leaves data high
// - master nack ends read; release data
// - slave holds clock low to delay
// - stretch always transmitting; receiving only clock_release_bit clear
// - repeated start follows acknowledge, keeps bus
// - full slave protocol, no general call
// - bit rate follows master clock
// - ack is data low, nack high
// - bits sampled on clock rising edge
// - ten-bit first byte: 11110, A9 A8, direction
`timescale 1ns/1ps
module twp_port (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    twp_pkg::twp_st_t  st;
    twp_pkg::twp_aph_t aph;
    logic [3:0]        cnt;
    logic [7:0]        rxtx;
    logic [7:0]        ctl;
    logic [7:0]        sts;
    logic [7:0]        flg;
    logic [7:0]        ien;
    logic [7:0]        sadr;
    logic              tx;
    logic              hi10;
    logic              mack;
    logic              sda_drv;
    logic              scl_hold;
    logic [7:0]        rdata;
    logic              serr;
  } twp_core_t;

  localparam twp_core_t CORE_RST = '{
    st:       twp_pkg::ST_IDLE,
    aph:      twp_pkg::AP_FIRST,
    cnt:      4'h0,
    rxtx:     twp_pkg::RST_BUF,
    ctl:      twp_pkg::RST_CTL,
    sts:      twp_pkg::RST_STS,
    flg:      twp_pkg::RST_FLG,
    ien:      twp_pkg::RST_IEN,
    sadr:     twp_pkg::RST_ADR,
    tx:       1'b0,
    hi10:     1'b0,
    mack:     1'b0,
    sda_drv:  1'b0,
    scl_hold: 1'b0,
    rdata:    8'h00,
    serr:     1'b0
  };

  twp_core_t   q_ff;
  twp_core_t   nxt_q;
  logic        scl_lvl;
  logic        scl_rise;
  logic        scl_fall;
  logic        sda_lvl;
  logic        sda_rise;
  logic        sda_fall;
  logic [7:0]  sr;
  logic        sh_en;
  logic        sh_ld;
  logic [7:0]  sh_val;
  logic        wr_acc;
  logic        rd_acc;
  logic        start_det;
  logic        stop_det;
  logic        slave_on;
  logic        i2c_on;
  logic        sp_irq;
  logic        ten;
  logic        addr_hit;
  logic        take;

  // ------------------------------------------------------------
  // line sampling and shift register
  // ------------------------------------------------------------
  // bus lines come from outside pclk, so both pass two flops first
  twp_sync u_scl_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (scl_i),
    .lvl     (scl_lvl),
    .rise    (scl_rise),
    .fall    (scl_fall)
  );

  twp_sync u_sda_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (sda_i),
    .lvl     (sda_lvl),
    .rise    (sda_rise),
    .fall    (sda_fall)
  );

  twp_shreg #(
    .W (8)
  ) u_shreg (
    .pclk    (pclk),
    .presetn (presetn),
    .ld      (sh_ld),
    .ld_val  (sh_val),
    .sh      (sh_en),
    .sh_bit  (sda_lvl),
    .q       (sr)
  );

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic mapped(input logic [9:0] a);
    case (a)
      twp_pkg::A_FLG, twp_pkg::A_BUF, twp_pkg::A_CTL,
      twp_pkg::A_ADR, twp_pkg::A_IEN, twp_pkg::A_STS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  function automatic logic is_mode(input logic [3:0] m, input logic [3:0] c);
    is_mode = (m == c);
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_q    = q_ff;
    sh_en    = 1'b0;
    sh_ld    = 1'b0;
    sh_val   = 8'h00;
    addr_hit = 1'b0;
    take     = 1'b0;
    wr_acc   = psel & penable & pwrite & ~q_ff.serr;
    rd_acc   = psel & penable & ~pwrite & ~q_ff.serr;
    // start/stop while clock high; own data edges only happen clock low
    start_det = scl_lvl & sda_fall;
    stop_det  = scl_lvl & sda_rise;
    slave_on  = q_ff.ctl[twp_pkg::CTL_EN] &
                (is_mode(q_ff.ctl[3:0], twp_pkg::MODE_S7) | is_mode(q_ff.ctl[3:0], twp_pkg::MODE_S10) |
                 is_mode(q_ff.ctl[3:0], twp_pkg::MODE_S7_SP) | is_mode(q_ff.ctl[3:0], twp_pkg::MODE_S10_SP));
    i2c_on    = slave_on | (q_ff.ctl[twp_pkg::CTL_EN] & is_mode(q_ff.ctl[3:0], twp_pkg::MODE_FW_MST));
    sp_irq    = is_mode(q_ff.ctl[3:0], twp_pkg::MODE_S7_SP) | is_mode(q_ff.ctl[3:0], twp_pkg::MODE_S10_SP) |
                is_mode(q_ff.ctl[3:0], twp_pkg::MODE_FW_MST);
    ten       = is_mode(q_ff.ctl[3:0], twp_pkg::MODE_S10) | is_mode(q_ff.ctl[3:0], twp_pkg::MODE_S10_SP);

    // apb setup phase: capture read data so prdata comes from a flop
    if (psel && !penable) begin
      nxt_q.serr = ~mapped(paddr);
      case (paddr)
        twp_pkg::A_FLG: nxt_q.rdata = q_ff.flg;
        twp_pkg::A_BUF: nxt_q.rdata = q_ff.rxtx;
        twp_pkg::A_CTL: nxt_q.rdata = q_ff.ctl;
        twp_pkg::A_ADR: nxt_q.rdata = q_ff.sadr;
        twp_pkg::A_IEN: nxt_q.rdata = q_ff.ien;
        twp_pkg::A_STS: nxt_q.rdata = q_ff.sts;
        default:        nxt_q.rdata = 8'h00;
      endcase
    end

    // software writes first, so hardware sets below win
    if (wr_acc) begin
      case (paddr)
        twp_pkg::A_FLG: nxt_q.flg = pwdata[7:0];
        twp_pkg::A_IEN: nxt_q.ien = pwdata[7:0];
        twp_pkg::A_CTL: nxt_q.ctl = pwdata[7:0];
        twp_pkg::A_STS: nxt_q.sts[7:6] = pwdata[7:6];
        twp_pkg::A_ADR: begin
          nxt_q.sadr = pwdata[7:0];
          nxt_q.sts[twp_pkg::STS_UA] = 1'b0;
        end
        twp_pkg::A_BUF: begin
          if (q_ff.st == twp_pkg::ST_TX && q_ff.scl_hold && q_ff.cnt == 4'h0) begin
            sh_ld         = 1'b1;
            sh_val        = pwdata[7:0];
            nxt_q.rxtx    = pwdata[7:0];
            nxt_q.sda_drv = ~pwdata[7];
          end else if (q_ff.st == twp_pkg::ST_TX || q_ff.st == twp_pkg::ST_TXACK) begin
            // shifting in progress: write is dropped
            nxt_q.ctl[twp_pkg::CTL_WRITE_COLLISION_FLAG] = 1'b1;
          end else begin
            nxt_q.rxtx = pwdata[7:0];
          end
        end
        default: ;
      endcase
    end
    if (rd_acc && paddr == twp_pkg::A_BUF) begin
      nxt_q.sts[twp_pkg::STS_BF] = 1'b0;
    end

    // start and stop reported in every two-wire mode
    if (i2c_on && start_det) begin
      nxt_q.sts[twp_pkg::STS_START] = 1'b1;
      nxt_q.sts[twp_pkg::STS_STOP]  = 1'b0;
      if (sp_irq) begin
        nxt_q.flg[twp_pkg::FLG_PORT] = 1'b1;
      end
    end
    if (i2c_on && stop_det) begin
      nxt_q.sts[twp_pkg::STS_STOP]  = 1'b1;
      nxt_q.sts[twp_pkg::STS_START] = 1'b0;
      if (sp_irq) begin
        nxt_q.flg[twp_pkg::FLG_PORT] = 1'b1;
      end
    end

    if (!slave_on) begin
      // port off or not a slave mode: lines released
      nxt_q.st       = twp_pkg::ST_IDLE;
      nxt_q.sda_drv  = 1'b0;
      nxt_q.scl_hold = 1'b0;
      nxt_q.hi10     = 1'b0;
    end else if (stop_det) begin
      // a stop anywhere, even in the acknowledge pulse, ends the transfer
      nxt_q.st       = twp_pkg::ST_IDLE;
      nxt_q.sda_drv  = 1'b0;
      nxt_q.scl_hold = 1'b0;
      nxt_q.hi10     = 1'b0;
    end else if (start_det) begin
      // repeated start keeps hi10 so a ten-bit read can follow
      nxt_q.st      = twp_pkg::ST_RX;
      nxt_q.aph     = twp_pkg::AP_FIRST;
      nxt_q.cnt     = 4'h0;
      nxt_q.tx      = 1'b0;
      nxt_q.sda_drv = 1'b0;
    end else begin
      case (q_ff.st)
        twp_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_en     = 1'b1;
            nxt_q.cnt = q_ff.cnt + 4'h1;
          end else if (scl_fall && q_ff.cnt == twp_pkg::BITS_PER_BYTE) begin
            nxt_q.cnt = 4'h0;
            nxt_q.st  = twp_pkg::ST_ACK;
            case (q_ff.aph)
              twp_pkg::AP_FIRST: begin
                // general call never matches; ten-bit read needs earlier match
                addr_hit = sr[7:1] == q_ff.sadr[7:1] && sr[7:1] != twp_pkg::GEN_CALL &&
                           (!ten || (sr[7:3] == twp_pkg::TEN_BIT_TAG && (!sr[0] || q_ff.hi10)));
              end
              twp_pkg::AP_SECOND: addr_hit = sr == q_ff.sadr;
              default:            addr_hit = 1'b1;
            endcase
            take = addr_hit & ~q_ff.sts[twp_pkg::STS_BF] & ~q_ff.ctl[twp_pkg::CTL_OVF];
            if (!addr_hit) begin
              nxt_q.st = twp_pkg::ST_SKIP;
            end else begin
              nxt_q.flg[twp_pkg::FLG_PORT] = 1'b1;
              nxt_q.sts[twp_pkg::STS_DNA]  = q_ff.aph == twp_pkg::AP_DATA;
              if (q_ff.aph == twp_pkg::AP_FIRST) begin
                nxt_q.sts[twp_pkg::STS_RNW] = sr[0];
                nxt_q.tx  = sr[0] & take;
                nxt_q.aph = (ten && !sr[0]) ? twp_pkg::AP_SECOND : twp_pkg::AP_DATA;
                if (ten && !sr[0]) begin
                  nxt_q.sts[twp_pkg::STS_UA] = 1'b1;
                end
              end else if (q_ff.aph == twp_pkg::AP_SECOND) begin
                nxt_q.hi10 = 1'b1;
                nxt_q.aph  = twp_pkg::AP_DATA;
                nxt_q.sts[twp_pkg::STS_UA] = 1'b1;
              end
              if (take) begin
                nxt_q.rxtx    = sr;
                nxt_q.sts[twp_pkg::STS_BF] = 1'b1;
                nxt_q.sda_drv = 1'b1;
              end else if (q_ff.sts[twp_pkg::STS_BF]) begin
                // byte lost, no acknowledge: data stays high
                nxt_q.ctl[twp_pkg::CTL_OVF] = 1'b1;
              end
            end
          end
        end
        twp_pkg::ST_ACK: begin
          if (scl_fall) begin
            // end of ninth pulse: release data, maybe stretch
            nxt_q.sda_drv = 1'b0;
            nxt_q.cnt     = 4'h0;
            if (q_ff.tx) begin
              nxt_q.st       = twp_pkg::ST_TX;
              nxt_q.scl_hold = 1'b1;
              nxt_q.ctl[twp_pkg::CTL_CKP] = 1'b0;
            end else begin
              nxt_q.st = twp_pkg::ST_RX;
              if (!q_ff.ctl[twp_pkg::CTL_CKP]) begin
                nxt_q.scl_hold = 1'b1;
              end
            end
          end
        end
        twp_pkg::ST_TX: begin
          if (scl_rise) begin
            nxt_q.cnt = q_ff.cnt + 4'h1;
          end else if (scl_fall) begin
            if (q_ff.cnt == twp_pkg::BITS_PER_BYTE) begin
              nxt_q.sda_drv = 1'b0;
              nxt_q.st      = twp_pkg::ST_TXACK;
            end else begin
              sh_en         = 1'b1;
              nxt_q.sda_drv = ~sr[6];
            end
          end
        end
        twp_pkg::ST_TXACK: begin
          if (scl_rise) begin
            nxt_q.mack = ~sda_lvl;
          end else if (scl_fall) begin
            nxt_q.cnt = 4'h0;
            if (q_ff.mack) begin
              nxt_q.st       = twp_pkg::ST_TX;
              nxt_q.scl_hold = 1'b1;
              nxt_q.ctl[twp_pkg::CTL_CKP]  = 1'b0;
              nxt_q.flg[twp_pkg::FLG_PORT] = 1'b1;
            end else begin
              // last byte read: leave the bus to the master's stop
              nxt_q.st = twp_pkg::ST_SKIP;
            end
          end
        end
        twp_pkg::ST_SKIP: nxt_q.sda_drv = 1'b0;
        default:          nxt_q.st = twp_pkg::ST_IDLE;
      endcase
    end

    // software sets clock_release_bit to let the master go on
    if (nxt_q.ctl[twp_pkg::CTL_CKP]) begin
      nxt_q.scl_hold = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= CORE_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // zero-wait slave; bit rate is whatever the master clocks
  assign pready  = psel & penable;
  assign pslverr = psel & penable & q_ff.serr;
  assign prdata  = {24'h000000, q_ff.rdata};
  // open drain: only ever pull low or let go
  assign scl_o   = 1'b0;
  assign sda_o   = 1'b0;
  assign scl_oe  = q_ff.scl_hold;
  assign sda_oe  = q_ff.sda_drv;
endmodule // twp_port

/* dv/twp_port_properties.sv */
// checker: concurrent properties on the apb side and bus pins of the port
`timescale 1ns/1ps
module twp_port_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [9:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe
);
  // ------------------------------------------------------------
  // helper: own view of the bus, start sets busy, stop clears it
  // ------------------------------------------------------------
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic       busy_ff;
  logic       mapped;
  logic       ctl_wr;
  assign mapped = paddr inside {twp_pkg::A_FLG, twp_pkg::A_BUF, twp_pkg::A_CTL,
                                twp_pkg::A_ADR, twp_pkg::A_IEN, twp_pkg::A_STS};
  assign ctl_wr = psel && penable && pwrite && (paddr == twp_pkg::A_CTL);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s   <= 2'b11;
      sda_s   <= 2'b11;
      busy_ff <= 1'b0;
    end else begin
      scl_s   <= {scl_s[0], scl_i};
      sda_s   <= {sda_s[0], sda_i};
      if (scl_s[1] && scl_s[0] && sda_s[1] != sda_s[0]) begin
        busy_ff <= sda_s[1];
      end
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rel_req_s;
    ctl_wr && pwdata[twp_pkg::CTL_CKP] && scl_oe;
  endsequence
  sequence idle_s;
    !busy_ff [*4];
  endsequence
  chk_apb_zero_wait: assert property (psel && penable |-> pready && prdata[31:8] == 24'h0)
    else $error("access phase without ready");
  chk_setup_quiet: assert property (psel && !penable |-> !pready && !pslverr)
    else $error("ready or error in setup cycle");
  chk_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
    else $error("slave error does not follow address map");
  chk_open_drain: assert property (1'b1 |-> !scl_o && !sda_o)
    else $error("pin driven high");
  chk_idle_release: assert property (idle_s |-> !sda_oe && !scl_oe)
    else $error("line pulled on idle bus");
  chk_data_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data changed with clock high");
  chk_stretch_low: assert property ($rose(scl_oe) |-> !scl_i)
    else $error("stretch began with clock high");
  chk_stretch_hold: assert property (scl_oe && !ctl_wr |=> scl_oe)
    else $error("stretch dropped without release");
  chk_stretch_release: assert property (rel_req_s |=> ##[0:1] !scl_oe)
    else $error("stretch not released");
endmodule // twp_port_properties

bind twp_port twp_port_properties twp_port_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe)
);

/* dv/twp_mst.sv */
// model: two-wire bus master, 160 ns bit period, waits out stretches
`timescale 1ns/1ps
module twp_mst (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_pull,
  output logic      sda_pull
);
  // ------------------------------------------------------------
  // lines released at start, pull-ups give the idle level
  // ------------------------------------------------------------
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // ------------------------------------------------------------
  // bit level
  // ------------------------------------------------------------
  task automatic rise();
    scl_pull = 1'b0;
    wait (scl === 1'b1);
  endtask
  task automatic bitw(input logic b);
    sda_pull = !b;
    #40 rise();
    #80 scl_pull = 1'b1;
    #40;
  endtask
  task automatic bitr(output logic b);
    sda_pull = 1'b0;
    #40 rise();
    #40 b = sda;
    #40 scl_pull = 1'b1;
    #40;
  endtask
  // ------------------------------------------------------------
  // frame level
  // ------------------------------------------------------------
  task automatic start();
    if (scl_pull) begin
      sda_pull = 1'b0;
      #40 rise();
    end
    #80 sda_pull = 1'b1;
    #80 scl_pull = 1'b1;
    #40;
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    #40 rise();
    #80 sda_pull = 1'b0;
    #80;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ak);
    logic b;
    for (int i = 7; i >= 0; i--) bitw(d[i]);
    bitr(b);
    ak = !b;
  endtask
  task automatic rbyte(output logic [7:0] d, input logic ak);
    for (int i = 7; i >= 0; i--) bitr(d[i]);
    bitw(!ak);
  endtask
  task automatic rstop(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bitr(d[i]);
    stop();
  endtask
endmodule // twp_mst

/* dv/two_wire_bus_protocol_port_tb.sv */
// testbench: apb register access and two-wire slave transfers
`timescale 1ns/1ps
module two_wire_bus_protocol_port_tb;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe;
  logic        scl_pull, sda_pull, e, ak;
  logic [7:0]  q, d;
  int          n_fail, num_checks;
  wire         scl = !(scl_oe | scl_pull);
  wire         sda = !(sda_oe | sda_pull);
  twp_port twp_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe));
  twp_mst twp_mst_inst (.scl(scl), .sda(sda), .scl_pull(scl_pull), .sda_pull(sda_pull));
  always #4 pclk = ~pclk;
  // ------------------------------------------------------------
  // access and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) chk({7'h0, pready}, 8'h01);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(q, exp);
  endtask
  task automatic pin(input logic sel_scl, input logic exp);
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    chk({7'h0, sel_scl ? scl_oe : sda_oe}, {7'h0, exp});
  endtask
  task automatic final_report();
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    n_fail = 0; num_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(twp_pkg::A_FLG, 8'h00);
    rd(twp_pkg::A_CTL, 8'h00);
    rd(twp_pkg::A_STS, 8'h00);
    apb(1'b1, twp_pkg::A_IEN, 8'hff);
    rd(twp_pkg::A_IEN, 8'hff);
    apb(1'b0, 10'h3fc, 8'h00);
    chk({7'h0, e}, 8'h01);
    $display("test registers done");
    apb(1'b1, twp_pkg::A_ADR, 8'h5a);
    apb(1'b1, twp_pkg::A_CTL, 8'h36);
    twp_mst_inst.start();
    twp_mst_inst.wbyte(8'h5a, ak); chk({7'h0, ak}, 8'h01);
    rd(twp_pkg::A_BUF, 8'h5a);
    twp_mst_inst.wbyte(8'ha5, ak); chk({7'h0, ak}, 8'h01);
    apb(1'b0, twp_pkg::A_STS, 8'h00); chk(q & 8'h25, 8'h21);
    rd(twp_pkg::A_FLG, 8'h08);
    apb(1'b1, twp_pkg::A_FLG, 8'h00);
    rd(twp_pkg::A_BUF, 8'ha5);
    twp_mst_inst.wbyte(8'h11, ak);
    twp_mst_inst.wbyte(8'h22, ak); chk({7'h0, ak}, 8'h00);
    apb(1'b0, twp_pkg::A_CTL, 8'h00); chk(q & 8'h40, 8'h40);
    rd(twp_pkg::A_BUF, 8'h11);
    twp_mst_inst.stop();
    apb(1'b0, twp_pkg::A_STS, 8'h00); chk(q & 8'h10, 8'h10);
    apb(1'b1, twp_pkg::A_CTL, 8'h36);
    $display("test write done");
    apb(1'b1, twp_pkg::A_ADR, 8'h00);
    for (int i = 0; i < 2; i++) begin
      twp_mst_inst.start();
      twp_mst_inst.wbyte(i ? 8'h5c : 8'h00, ak); chk({7'h0, ak}, 8'h00);
      twp_mst_inst.stop();
    end
    apb(1'b1, twp_pkg::A_ADR, 8'h5a);
    $display("test refused done");
    apb(1'b1, twp_pkg::A_CTL, 8'h26);
    twp_mst_inst.start();
    twp_mst_inst.wbyte(8'h5a, ak);
    pin(1'b1, 1'b1);
    rd(twp_pkg::A_BUF, 8'h5a);
    apb(1'b1, twp_pkg::A_CTL, 8'h36);
    pin(1'b1, 1'b0);
    twp_mst_inst.start();
    twp_mst_inst.wbyte(8'h5b, ak); chk({7'h0, ak}, 8'h01);
    pin(1'b1, 1'b1);
    apb(1'b0, twp_pkg::A_STS, 8'h00); chk(q & 8'h04, 8'h04);
    rd(twp_pkg::A_BUF, 8'h5b);
    apb(1'b1, twp_pkg::A_BUF, 8'hc3);
    apb(1'b1, twp_pkg::A_CTL, 8'h36);
    twp_mst_inst.rbyte(d, 1'b1); chk(d, 8'hc3);
    pin(1'b1, 1'b1);
    apb(1'b1, twp_pkg::A_BUF, 8'h3c);
    apb(1'b1, twp_pkg::A_CTL, 8'h36);
    twp_mst_inst.rbyte(d, 1'b0); chk(d, 8'h3c);
    pin(1'b0, 1'b0);
    twp_mst_inst.stop();
    $display("test read done");
    twp_mst_inst.start();
    twp_mst_inst.wbyte(8'h5b, ak); chk({7'h0, ak}, 8'h01);
    rd(twp_pkg::A_BUF, 8'h5b);
    apb(1'b1, twp_pkg::A_BUF, 8'h96);
    apb(1'b1, twp_pkg::A_CTL, 8'h3e);
    apb(1'b1, twp_pkg::A_FLG, 8'h00);
    twp_mst_inst.rstop(d); chk(d, 8'h96);
    rd(twp_pkg::A_FLG, 8'h08);
    apb(1'b0, twp_pkg::A_STS, 8'h00); chk(q & 8'h10, 8'h10);
    $display("test stop in ack done");
    apb(1'b1, twp_pkg::A_CTL, 8'h37);
    apb(1'b1, twp_pkg::A_ADR, 8'hf2);
    twp_mst_inst.start();
    twp_mst_inst.wbyte(8'hf2, ak); chk({7'h0, ak}, 8'h01);
    apb(1'b0, twp_pkg::A_STS, 8'h00); chk(q & 8'h02, 8'h02);
    rd(twp_pkg::A_BUF, 8'hf2);
    apb(1'b1, twp_pkg::A_ADR, 8'h6b);
    twp_mst_inst.wbyte(8'h6b, ak); chk({7'h0, ak}, 8'h01);
    rd(twp_pkg::A_BUF, 8'h6b);
    twp_mst_inst.stop();
    $display("test ten-bit done");
    final_report();
  end
  // ------------------------------------------------------------
  // watchdog: run needs well under 100 us
  // ------------------------------------------------------------
  initial begin
    #200000;
    n_fail++;
    $display("Error t=%0t timeout %h %h", $time, num_checks, n_fail);
    final_report();
  end
endmodule // two_wire_bus_protocol_port_tb
